// *** pkg/adcdc_pkg.sv ***
package adcdc_pkg;
  // word index of each documented register; byte address is index * 4
  localparam logic [11:0] COMPARE_CONTROL_INDEX = 12'h33C;
  localparam logic [11:0] FAULT_INJECT_INDEX = 12'h33D;
  localparam logic [11:0] PROTECTOR_INDEX = 12'h33E;
  localparam logic [11:0] COMPARE_CONTROL_ADDR = 12'hCF0;
  localparam logic [11:0] FAULT_INJECT_ADDR = 12'hCF4;
  localparam logic [11:0] PROTECTOR_ADDR = 12'hCF8;
  localparam logic [11:0] SWITCH_OVERRIDE_ADDR = 12'hD00;
  localparam logic [11:0] DIAG_STATUS_ADDR = 12'hD04;
  localparam logic [11:0] DIAG_CONFIG_ADDR = 12'hD08;
  // compare control fields
  localparam int CC_GO_BIT = 0;
  localparam int CC_SEL_LSB = 1;
  localparam int CC_SINK_LSB = 4;
  localparam int CC_SWGO_BIT = 6;
  // fault inject fields
  localparam int FI_FILTER_BIT = 0;
  localparam int FI_COMPARE_BIT = 1;
  // config fields
  localparam int CFG_AUXSEL_LSB = 0;
  localparam int CFG_CELLTHR_LSB = 8;
  localparam int CFG_OWTHR_LSB = 16;
  localparam int CFG_INTHR_LSB = 20;
  localparam int CFG_EXTEND_BIT = 24;
  // status fields
  localparam int ST_READY_LSB = 0;
  localparam int ST_PASS_LSB = 8;
  localparam int ST_FILTER_BIT = 16;
  localparam int ST_BUSY_BIT = 17;
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [31:0] REG32_RESET = 32'h00000000;
  // threshold scales, millivolts
  localparam logic [17:0] CELL_DELTA_BASE_MV = 18'd6;
  localparam logic [17:0] CELL_DELTA_STEP_MV = 18'd3;
  localparam logic [17:0] OPEN_WIRE_BASE_MV = 18'd500;
  localparam logic [17:0] OPEN_WIRE_STEP_MV = 18'd300;
  localparam logic [17:0] INPUT_DELTA_BASE_MV = 18'd4;
  localparam logic [17:0] INPUT_DELTA_STEP_MV = 18'd4;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ADCDC_SEL_NONE = 3'b000,
    ADCDC_SEL_CELL = 3'b001,
    ADCDC_SEL_SENSE_OW = 3'b010,
    ADCDC_SEL_BALANCE_OW = 3'b011,
    ADCDC_SEL_SWITCH = 3'b100,
    ADCDC_SEL_INPUT = 3'b101
  } adcdc_sel_type;

  typedef enum logic [1:0] {
    ADCDC_SINK_OFF = 2'b00,
    ADCDC_SINK_SENSE = 2'b01,
    ADCDC_SINK_BALANCE = 2'b10,
    ADCDC_SINK_BUSBAR = 2'b11
  } adcdc_sink_type;

  typedef enum logic [1:0] {
    ADCDC_IDLE = 2'b00,
    ADCDC_SCAN = 2'b01,
    ADCDC_DONE = 2'b10
  } adcdc_state_type;
endpackage : adcdc_pkg

// *** hw/adcdc_compare_control.sv ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module adcdc_compare_control
  import adcdc_pkg::*;
#(
  parameter int NUM_CELLS = 16,
  parameter int NUM_INPUTS = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic balancing_running,
  input wire logic [NUM_CELLS-1:0] balancing_switch_request,
  input wire logic [NUM_CELLS-1:0] active_cell_mask,
  input wire logic [NUM_INPUTS-1:0] input_analog_mask,
  input wire logic [15:0] main_value,
  input wire logic [15:0] aux_value,
  input wire logic filter_diag_active,
  output logic [4:0] compare_channel,
  output logic compare_on_inputs,
  output logic [NUM_CELLS-1:0] balance_switch,
  output logic sense_sink_en,
  output logic balance_sink_en,
  output logic busbar_sink_en,
  output logic filter_fault_force,
  output logic protector_selftest_keep_faults
);
  logic [11:0] aw_addr, next_aw_addr;
  logic aw_full, next_aw_full;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic w_full, next_w_full;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [1:0] sink_select, next_sink_select;
  logic [2:0] compare_select, next_compare_select;
  logic [1:0] fault_inject, next_fault_inject;
  logic keep_faults, next_keep_faults;
  logic [31:0] switch_override_regs, next_switch_override_regs;
  logic [31:0] diag_config, next_diag_config;
  logic [4:0] ready_flags, next_ready_flags;
  logic [4:0] pass_flags, next_pass_flags;
  logic filter_failure_flag, next_filter_failure_flag;
  adcdc_state_type state, next_state;
  logic [2:0] captured_select, next_captured_select;
  logic [4:0] channel, next_channel;
  logic failed, next_failed;
  logic override_active, next_override_active;
  logic [NUM_CELLS-1:0] override_pattern, next_override_pattern;
  logic running_d, next_running_d;

  logic do_write, do_read, write_hit, read_hit;
  logic [31:0] read_word, cc_word;
  logic [4:0] aux_select, last_channel;
  logic channel_enabled, channel_fails;
  logic [15:0] delta;
  logic [17:0] cell_thr, ow_thr, in_thr;
  logic [17:0] aux_times_three;

  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0] strb);
    logic [31:0] result;
    result = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        result[8*b +: 8] = new_word[8*b +: 8];
    end
    return result;
  endfunction : merge

  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign do_write = aw_full && w_full && !bvalid;
  assign do_read = s_axi_arvalid && !rvalid;
  assign aux_select = diag_config[CFG_AUXSEL_LSB +: 5];
  assign last_channel = (captured_select == ADCDC_SEL_INPUT) ?
                        5'(NUM_INPUTS - 1) : 5'(NUM_CELLS - 1);
  assign compare_channel = channel;
  assign compare_on_inputs = (captured_select == ADCDC_SEL_INPUT);
  assign filter_fault_force = fault_inject[FI_FILTER_BIT];
  assign protector_selftest_keep_faults = keep_faults;
  // sinks follow the stored select directly
  assign sense_sink_en = (sink_select == ADCDC_SINK_SENSE);
  assign balance_sink_en = (sink_select == ADCDC_SINK_BALANCE);
  assign busbar_sink_en = (sink_select == ADCDC_SINK_BUSBAR);

  genvar g;
  generate
    for (g = 0; g < NUM_CELLS; g++)
    begin : gen_switch
      assign balance_switch[g] = override_active ? override_pattern[g] :
                                 balancing_switch_request[g];
    end
  endgenerate

  // threshold scaling
  always_comb
  begin
    cell_thr = CELL_DELTA_BASE_MV +
      18'(diag_config[CFG_CELLTHR_LSB +: 5]) * CELL_DELTA_STEP_MV;
    ow_thr = OPEN_WIRE_BASE_MV +
      18'(diag_config[CFG_OWTHR_LSB +: 4]) * OPEN_WIRE_STEP_MV;
    in_thr = INPUT_DELTA_BASE_MV +
      18'(diag_config[CFG_INTHR_LSB +: 3]) * INPUT_DELTA_STEP_MV;
    delta = (main_value >= aux_value) ? main_value - aux_value :
            aux_value - main_value;
    aux_times_three = 18'(aux_value) * 18'd3;
    channel_enabled = 1'b0;
    channel_fails = 1'b0;
    unique case (captured_select)
      ADCDC_SEL_CELL:
      begin
        channel_enabled = (aux_select == 5'h00) || (aux_select == channel + 5'h01);
        channel_fails = 18'(delta) >= cell_thr;
      end
      ADCDC_SEL_SENSE_OW:
      begin
        channel_enabled = active_cell_mask[channel[3:0]];
        channel_fails = 18'(main_value) >= ow_thr;
      end
      ADCDC_SEL_BALANCE_OW:
      begin
        channel_enabled = (aux_select == 5'h00) || (aux_select == channel + 5'h01);
        channel_fails = 18'(aux_value) >= ow_thr;
      end
      ADCDC_SEL_SWITCH:
      begin
        channel_enabled = (aux_select == 5'h00) || (aux_select == channel + 5'h01);
        channel_fails = aux_times_three >= 18'(main_value);
      end
      ADCDC_SEL_INPUT:
      begin
        channel_enabled = input_analog_mask[channel[2:0]];
        channel_fails = 18'(delta) >= in_thr;
      end
      default:
      begin
        channel_enabled = 1'b0;
        channel_fails = 1'b0;
      end
    endcase
  end

  // register read mux
  always_comb
  begin
    cc_word = 32'h00000000;
    cc_word[CC_SINK_LSB +: 2] = sink_select;
    cc_word[CC_SEL_LSB +: 3] = compare_select;
    read_hit = 1'b1;
    read_word = 32'h00000000;
    unique case (s_axi_araddr)
      COMPARE_CONTROL_ADDR: read_word = cc_word;
      FAULT_INJECT_ADDR: read_word = {30'h00000000, fault_inject};
      PROTECTOR_ADDR: read_word = {31'h00000000, keep_faults};
      SWITCH_OVERRIDE_ADDR: read_word = switch_override_regs;
      DIAG_CONFIG_ADDR: read_word = diag_config;
      DIAG_STATUS_ADDR:
      begin
        read_word[ST_READY_LSB +: 5] = ready_flags;
        read_word[ST_PASS_LSB +: 5] = pass_flags;
        read_word[ST_FILTER_BIT] = filter_failure_flag;
        read_word[ST_BUSY_BIT] = (state != ADCDC_IDLE);
      end
      default: read_hit = 1'b0;
    endcase
    write_hit = (aw_addr == COMPARE_CONTROL_ADDR) ||
                (aw_addr == FAULT_INJECT_ADDR) ||
                (aw_addr == PROTECTOR_ADDR) ||
                (aw_addr == SWITCH_OVERRIDE_ADDR) ||
                (aw_addr == DIAG_CONFIG_ADDR) ||
                (aw_addr == DIAG_STATUS_ADDR);
  end

  always_comb
  begin
    logic [31:0] wr;
    logic compare_go, switch_go, lo_byte;
    logic [4:0] ready_set;
    logic [4:0] ready_clr;
    logic filter_clr;
    wr = merge(32'h00000000, w_data, w_strb);
    lo_byte = w_strb[0];
    compare_go = 1'b0;
    switch_go = 1'b0;
    ready_set = 5'h00;
    ready_clr = 5'h00;
    filter_clr = 1'b0;
    next_aw_addr = aw_addr;
    next_aw_full = aw_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_w_full = w_full;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_sink_select = sink_select;
    next_compare_select = compare_select;
    next_fault_inject = fault_inject;
    next_keep_faults = keep_faults;
    next_switch_override_regs = switch_override_regs;
    next_diag_config = diag_config;
    next_pass_flags = pass_flags;
    next_state = state;
    next_captured_select = captured_select;
    next_channel = channel;
    next_failed = failed;
    next_override_active = override_active;
    next_override_pattern = override_pattern;
    next_running_d = balancing_running;
    if (s_axi_awvalid && !aw_full)
    begin
      next_aw_addr = s_axi_awaddr;
      next_aw_full = 1'b1;
    end
    if (s_axi_wvalid && !w_full)
    begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_full = 1'b1;
    end
    if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (do_write)
    begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = write_hit ? AXI_OKAY : AXI_SLVERR;
      if (lo_byte)
      begin
        unique case (aw_addr)
          COMPARE_CONTROL_ADDR:
          begin
            next_sink_select = wr[CC_SINK_LSB +: 2];
            next_compare_select = wr[CC_SEL_LSB +: 3];
            compare_go = wr[CC_GO_BIT];
            switch_go = wr[CC_SWGO_BIT];
          end
          FAULT_INJECT_ADDR: next_fault_inject = wr[1:0];
          PROTECTOR_ADDR: next_keep_faults = wr[0];
          DIAG_STATUS_ADDR:
          begin
            ready_clr = wr[ST_READY_LSB +: 5];
            filter_clr = wr[ST_FILTER_BIT];
          end
          default:
          begin
          end
        endcase
      end
      if (aw_addr == SWITCH_OVERRIDE_ADDR)
        next_switch_override_regs = merge(switch_override_regs, w_data, w_strb);
      if (aw_addr == DIAG_CONFIG_ADDR)
        next_diag_config = merge(diag_config, w_data, w_strb);
    end
    if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (do_read)
    begin
      next_rvalid = 1'b1;
      next_rdata = read_word;
      next_rresp = read_hit ? AXI_OKAY : AXI_SLVERR;
    end
    // balancing start or resume hands switches back
    if (balancing_running && !running_d)
      next_override_active = 1'b0;
    if (switch_go && !balancing_running)
    begin
      next_override_active = 1'b1;
      next_override_pattern = switch_override_regs[NUM_CELLS-1:0];
    end
    unique case (state)
      ADCDC_IDLE:
      begin
        if (compare_go && wr[CC_SEL_LSB +: 3] >= ADCDC_SEL_CELL &&
            wr[CC_SEL_LSB +: 3] <= ADCDC_SEL_INPUT)
        begin
          next_captured_select = wr[CC_SEL_LSB +: 3];
          next_channel = 5'h00;
          next_failed = 1'b0;
          next_state = ADCDC_SCAN;
          if (wr[CC_SEL_LSB +: 3] == ADCDC_SEL_SWITCH && !balancing_running)
          begin
            next_override_active = 1'b1;
            next_override_pattern = switch_override_regs[NUM_CELLS-1:0];
          end
        end
      end
      ADCDC_SCAN:
      begin
        if (channel_enabled && channel_fails)
          next_failed = 1'b1;
        if (channel == last_channel)
          next_state = ADCDC_DONE;
        else
          next_channel = channel + 5'h01;
      end
      ADCDC_DONE:
      begin
        ready_set[captured_select - 3'd1] = 1'b1;
        next_pass_flags[captured_select - 3'd1] =
          !failed && !fault_inject[FI_COMPARE_BIT];
        if (captured_select == ADCDC_SEL_SWITCH && !diag_config[CFG_EXTEND_BIT])
          next_override_active = 1'b0;
        next_captured_select = ADCDC_SEL_NONE;
        next_channel = 5'h00;
        next_state = ADCDC_IDLE;
      end
      default: next_state = ADCDC_IDLE;
    endcase
    // set wins over a clear in the same cycle
    next_ready_flags = (ready_flags & ~ready_clr) | ready_set;
    next_filter_failure_flag = (filter_failure_flag && !filter_clr) ||
      (filter_diag_active && fault_inject[FI_FILTER_BIT]);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr <= 12'h000;
      aw_full <= 1'b0;
      w_data <= REG32_RESET;
      w_strb <= 4'h0;
      w_full <= 1'b0;
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
      rvalid <= 1'b0;
      rresp <= AXI_OKAY;
      rdata <= REG32_RESET;
      sink_select <= ADCDC_SINK_OFF;
      compare_select <= ADCDC_SEL_NONE;
      fault_inject <= 2'h0;
      keep_faults <= 1'b0;
      switch_override_regs <= REG32_RESET;
      diag_config <= REG32_RESET;
      ready_flags <= 5'h00;
      pass_flags <= 5'h00;
      filter_failure_flag <= 1'b0;
      state <= ADCDC_IDLE;
      captured_select <= ADCDC_SEL_NONE;
      channel <= 5'h00;
      failed <= 1'b0;
      override_active <= 1'b0;
      override_pattern <= '0;
      running_d <= 1'b0;
    end
    else
    begin
      aw_addr <= next_aw_addr;
      aw_full <= next_aw_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      w_full <= next_w_full;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      sink_select <= next_sink_select;
      compare_select <= next_compare_select;
      fault_inject <= next_fault_inject;
      keep_faults <= next_keep_faults;
      switch_override_regs <= next_switch_override_regs;
      diag_config <= next_diag_config;
      ready_flags <= next_ready_flags;
      pass_flags <= next_pass_flags;
      filter_failure_flag <= next_filter_failure_flag;
      state <= next_state;
      captured_select <= next_captured_select;
      channel <= next_channel;
      failed <= next_failed;
      override_active <= next_override_active;
      override_pattern <= next_override_pattern;
      running_d <= next_running_d;
    end
  end
endmodule : adcdc_compare_control
`default_nettype wire

// *** test/adcdc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcdc_checker
#(
  parameter int NUM_CELLS = 16,
  parameter int NUM_INPUTS = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic balancing_running,
  input wire logic [NUM_CELLS-1:0] balancing_switch_request,
  input wire logic [4:0] compare_channel,
  input wire logic [NUM_CELLS-1:0] balance_switch,
  input wire logic sense_sink_en,
  input wire logic balance_sink_en,
  input wire logic busbar_sink_en,
  input wire logic filter_fault_force
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sink_onehot: assert property (
    $onehot0({sense_sink_en, balance_sink_en, busbar_sink_en}))
    else $error("more than one sink group on");
  a_sink_cause: assert property (
    $changed({sense_sink_en, balance_sink_en, busbar_sink_en})
    |-> $rose(s_axi_bvalid)) else $error("sinks moved without a write");
  a_filter_cause: assert property (
    $changed(filter_fault_force) |-> $rose(s_axi_bvalid))
    else $error("filter force moved without a write");
  a_switch_normal: assert property (
    balancing_running && $past(balancing_running)
    && $past(balancing_running, 2) && $past(balancing_running, 3)
    |-> balance_switch == balancing_switch_request)
    else $error("override active while balancing runs");
  a_channel_range: assert property (
    compare_channel < 5'h10) else $error("scan index out of range");
  a_aw_block: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_release: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");

  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(filter_fault_force));
  cover property (balance_switch != balancing_switch_request);
  cover property ($rose(busbar_sink_en));
endmodule : adcdc_checker

bind adcdc_compare_control adcdc_checker #(
  .NUM_CELLS(NUM_CELLS),
  .NUM_INPUTS(NUM_INPUTS)
) chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .balancing_running(balancing_running),
  .balancing_switch_request(balancing_switch_request),
  .compare_channel(compare_channel), .balance_switch(balance_switch),
  .sense_sink_en(sense_sink_en), .balance_sink_en(balance_sink_en),
  .busbar_sink_en(busbar_sink_en), .filter_fault_force(filter_fault_force)
);
`default_nettype wire

// *** test/tb_adcdc_compare_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_adcdc_compare_control
  import adcdc_pkg::*;
;
  typedef struct {
    logic [2:0] sel;
    logic [15:0] m;
    logic [15:0] a;
    logic [31:0] cfg;
    logic inj;
    logic pass;
  } adcdc_row_type;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic balancing_running = 1'h0, filter_diag_active = 1'h0;
  logic [15:0] balancing_switch_request = 16'h0000;
  logic [15:0] active_cell_mask = 16'hFFFF;
  logic [7:0] input_analog_mask = 8'hFF;
  logic [15:0] main_value = 16'h0000, aux_value = 16'h0000;
  logic [4:0] compare_channel;
  logic compare_on_inputs, sense_sink_en, balance_sink_en, busbar_sink_en;
  logic [15:0] balance_switch;
  logic filter_fault_force, protector_selftest_keep_faults;
  int failures = 0;
  int samples_checked = 0;
  logic [31:0] no_start [4] = '{32'h00000001, 32'h00000002, 32'h0000000D,
                                32'h0000000F};
  // pass strictly below threshold; inject forces fail
  adcdc_row_type rows [15] = '{
    '{3'h1, 16'h0105, 16'h0100, 32'h00000000, 1'h0, 1'h1},
    '{3'h1, 16'h0106, 16'h0100, 32'h00000000, 1'h0, 1'h0},
    '{3'h1, 16'h0162, 16'h0100, 32'h00001F00, 1'h0, 1'h1},
    '{3'h2, 16'h01F3, 16'h0000, 32'h00000000, 1'h0, 1'h1},
    '{3'h2, 16'h01F4, 16'h0000, 32'h00000000, 1'h0, 1'h0},
    '{3'h2, 16'h1388, 16'h0000, 32'h000F0000, 1'h0, 1'h0},
    '{3'h3, 16'h0000, 16'h01F3, 32'h00000000, 1'h0, 1'h1},
    '{3'h3, 16'h0000, 16'h01F4, 32'h00000000, 1'h0, 1'h0},
    '{3'h4, 16'h012C, 16'h0063, 32'h00000000, 1'h0, 1'h1},
    '{3'h4, 16'h012C, 16'h0064, 32'h00000000, 1'h0, 1'h0},
    '{3'h5, 16'h0103, 16'h0100, 32'h00000000, 1'h0, 1'h1},
    '{3'h5, 16'h0104, 16'h0100, 32'h00000000, 1'h0, 1'h0},
    '{3'h1, 16'h0100, 16'h0100, 32'h00000000, 1'h1, 1'h0},
    '{3'h2, 16'h0000, 16'h0000, 32'h00000000, 1'h1, 1'h0},
    '{3'h4, 16'h012C, 16'h0000, 32'h00000000, 1'h1, 1'h0}};

  always #50 aclk = ~aclk;

  adcdc_compare_control uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .balancing_running(balancing_running),
    .balancing_switch_request(balancing_switch_request),
    .active_cell_mask(active_cell_mask),
    .input_analog_mask(input_analog_mask), .main_value(main_value),
    .aux_value(aux_value), .filter_diag_active(filter_diag_active),
    .compare_channel(compare_channel),
    .compare_on_inputs(compare_on_inputs),
    .balance_switch(balance_switch), .sense_sink_en(sense_sink_en),
    .balance_sink_en(balance_sink_en), .busbar_sink_en(busbar_sink_en),
    .filter_fault_force(filter_fault_force),
    .protector_selftest_keep_faults(protector_selftest_keep_faults)
  );

  task automatic conclude;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic check32(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      failures++;
      $display("ERROR t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : check32

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge aclk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axi_read

  task automatic wait_ready(input int bit_no);
    for (int n = 0; n < 40; n++)
    begin
      axi_read(DIAG_STATUS_ADDR);
      if (rd[bit_no] === 1'h1) break;
    end
  endtask : wait_ready

  task automatic run_cmp(input adcdc_row_type r);
    logic [31:0] msk;
    logic [31:0] want;
    main_value <= r.m;
    aux_value <= r.a;
    axi_write(DIAG_CONFIG_ADDR, r.cfg);
    axi_write(FAULT_INJECT_ADDR, {30'h0, r.inj, 1'h0});
    axi_write(COMPARE_CONTROL_ADDR, {28'h0, r.sel, 1'h1});
    check32(compare_on_inputs, {31'h0, r.sel == 3'h5});
    wait_ready(r.sel - 1);
    msk = 32'h0000001F | (32'h00000100 << (r.sel - 1));
    want = (32'h00000001 | {23'h0, r.pass, 8'h00}) << (r.sel - 1);
    check32(rd & msk, want);
    axi_write(DIAG_STATUS_ADDR, 32'h0000001F);
  endtask : run_cmp

  initial
  begin
    repeat (30000) @(posedge aclk);
    failures++;
    conclude();
  end

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[i]) run_cmp(rows[i]);
    // sink decode, effective on the write itself
    for (int k = 0; k < 4; k++)
    begin
      axi_write(COMPARE_CONTROL_ADDR, k << 4);
      check32({busbar_sink_en, balance_sink_en, sense_sink_en},
              (k == 0) ? 0 : 1 << (k - 1));
    end
    axi_write(COMPARE_CONTROL_ADDR, 32'h00000000);
    // select change without go starts no scan; the stored select still changes
    axi_write(COMPARE_CONTROL_ADDR, 32'h00000003);
    axi_write(COMPARE_CONTROL_ADDR, 32'h00000004);
    axi_read(COMPARE_CONTROL_ADDR);
    check32(rd, 32'h00000004);
    wait_ready(0);
    check32(rd & 32'h0000001F, 32'h00000001);
    axi_write(DIAG_STATUS_ADDR, 32'h0000001F);
    foreach (no_start[i]) axi_write(COMPARE_CONTROL_ADDR, no_start[i]);
    repeat (40) @(posedge aclk);
    axi_read(DIAG_STATUS_ADDR);
    check32(rd & 32'h0000001F, 32'h00000000);
    // switch override and hand-back
    balancing_switch_request <= 16'h0F0F;
    axi_write(SWITCH_OVERRIDE_ADDR, 32'h0000A5A5);
    axi_write(COMPARE_CONTROL_ADDR, 32'h00000040);
    check32(balance_switch, 32'h0000A5A5);
    axi_write(SWITCH_OVERRIDE_ADDR, 32'h000000FF);
    check32(balance_switch, 32'h0000A5A5);
    balancing_running <= 1'h1;
    repeat (3) @(posedge aclk);
    check32(balance_switch, 32'h00000F0F);
    axi_write(COMPARE_CONTROL_ADDR, 32'h00000040);
    check32(balance_switch, 32'h00000F0F);
    balancing_running <= 1'h0;
    repeat (3) @(posedge aclk);
    check32(balance_switch, 32'h00000F0F);
    // switch check with extend set keeps the pattern
    axi_write(DIAG_CONFIG_ADDR, 32'h01000000);
    axi_write(COMPARE_CONTROL_ADDR, 32'h00000009);
    check32(balance_switch, 32'h000000FF);
    wait_ready(3);
    check32(balance_switch, 32'h000000FF);
    // filter fault injection
    axi_write(FAULT_INJECT_ADDR, 32'h00000001);
    check32(filter_fault_force, 32'h00000001);
    filter_diag_active <= 1'h1;
    repeat (2) @(posedge aclk);
    filter_diag_active <= 1'h0;
    axi_read(DIAG_STATUS_ADDR);
    check32(rd & 32'h00010000, 32'h00010000);
    axi_write(DIAG_STATUS_ADDR, 32'h00010000);
    axi_read(DIAG_STATUS_ADDR);
    check32(rd & 32'h00010000, 32'h00000000);
    // protector bit, unmapped place, second reset
    axi_write(PROTECTOR_ADDR, 32'h00000001);
    check32(protector_selftest_keep_faults, 32'h00000001);
    axi_write(12'hFFC, 32'h00000001);
    check32(resp, AXI_SLVERR);
    axi_read(12'hFFC);
    check32(resp, AXI_SLVERR);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 0; k < 6; k++)
    begin
      axi_read((k < 3) ? COMPARE_CONTROL_ADDR + 12'(k * 4) :
               SWITCH_OVERRIDE_ADDR + 12'((k - 3) * 4));
      check32(resp, AXI_OKAY);
      check32(rd, REG32_RESET);
    end
    check32(protector_selftest_keep_faults, 32'h00000000);
    conclude();
  end
endmodule : tb_adcdc_compare_control
`default_nettype wire
